// *** hw/sde_encoder_top.sv ***
`timescale 1ns/1ps
`include "sde_consts.svh"
// ****************************************************
// diagnostic event encoder, top level
// ****************************************************
module sde_encoder_top #(
   parameter int FLASH_HALF_CYCLES = `SDE_FLASH_HALF_CYC
) (
   input  wire logic                  clock,
   input  wire logic                  rst,
   input  wire logic [7:0]            unavailFault,
   input  wire logic [7:0]            shortPFault,
   input  wire logic [7:0]            overloadFault,
   input  wire logic [7:0]            testFault,
   input  wire logic [7:0]            shortPEnable,
   input  wire logic                  appCaseTwo,
   input  wire logic                  destMismatch,
   input  wire logic                  destIllegal,
   input  wire logic                  srcIllegal,
   input  wire logic                  wdTimeZero,
   input  wire logic                  silExceeded,
   input  wire logic                  crcLenMismatch,
   input  wire logic                  parVersionBad,
   input  wire logic                  iparSaveTimeout,
   input  wire logic                  iparRestoreTimeout,
   input  wire logic                  iparInconsistent,
   input  wire logic                  msgCrcFault,
   input  wire logic                  commTimeout,
   input  wire logic                  intSupplyFault,
   input  wire logic                  addrMemFault,
   input  wire logic                  supplyHigh,
   input  wire logic                  supplyLow,
   input  wire logic                  userAck,
   input  wire logic                  intTaken,
   output logic                       intValid,
   output sde_pkg::sde_code_t         intCode,
   output sde_pkg::sde_scope_e        intScope,
   output logic [2:0]                 intChannel,
   output logic [7:0]                 chanEnabled,
   output logic                       supplyWait,
   output logic [7:0]                 channelIndicatorStatus,
   output logic [7:0]                 channelIndicatorDiag,
   output logic                       runLed,
   output logic                       errorLed
);
   localparam int NSRC = `SDE_NSRC;
   localparam int NMOD = `SDE_NMOD;

   initial begin
      if (`SDE_CODE_W < 12) $error("fault code field too narrow");
      if (FLASH_HALF_CYCLES < 1) $error("FLASH_HALF_CYCLES < 1");
   end

   // ****************************************************
   // decoding functions
   // ****************************************************

   // fault code of a source index
   function automatic sde_pkg::sde_code_t srcCode(
      input logic [5:0] idx
   );
      sde_pkg::sde_code_t c;
      c = `SDE_C_DESTMIS;
      if (idx >= 6'(`SDE_B_TESTFAIL)) c = `SDE_C_TESTFAIL;
      else if (idx >= 6'(`SDE_B_OVERLD)) c = `SDE_C_OVERLD;
      else if (idx >= 6'(`SDE_B_SHORTP)) c = `SDE_C_SHORTP;
      else if (idx >= 6'(`SDE_B_UNAVAIL)) c = `SDE_C_UNAVAIL;
      else begin
         case (idx)
            6'(`SDE_I_DESTMIS): c = `SDE_C_DESTMIS;
            6'(`SDE_I_DESTBAD): c = `SDE_C_DESTBAD;
            6'(`SDE_I_SRCBAD):  c = `SDE_C_SRCBAD;
            6'(`SDE_I_WDZERO):  c = `SDE_C_WDZERO;
            6'(`SDE_I_SILHIGH): c = `SDE_C_SILHIGH;
            6'(`SDE_I_CRCLEN):  c = `SDE_C_CRCLEN;
            6'(`SDE_I_PARVER):  c = `SDE_C_PARVER;
            6'(`SDE_I_SAVETO):  c = `SDE_C_SAVETO;
            6'(`SDE_I_RESTTO):  c = `SDE_C_RESTTO;
            6'(`SDE_I_IPARCRC): c = `SDE_C_IPARCRC;
            6'(`SDE_I_MSGCRC):  c = `SDE_C_MSGCRC;
            6'(`SDE_I_COMMTO):  c = `SDE_C_COMMTO;
            6'(`SDE_I_INTSUP):  c = `SDE_C_INTSUP;
            6'(`SDE_I_ADDRMEM): c = `SDE_C_ADDRMEM;
            6'(`SDE_I_SUPHIGH): c = `SDE_C_SUPHIGH;
            6'(`SDE_I_SUPLOW):  c = `SDE_C_SUPLOW;
            6'(`SDE_I_ACKREQ):  c = `SDE_C_ACKREQ;
            default:            c = `SDE_C_DESTMIS;
         endcase
      end
      return c;
   endfunction

   // lowest pending source index
   function automatic logic [5:0] firstSet(input logic [NSRC-1:0] v);
      logic [5:0] r;
      r = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (v[i]) r = 6'(i);
      end
      return r;
   endfunction

   // ****************************************************
   // channel fault and acknowledge state
   // ****************************************************
   logic [7:0] chanFault;
   logic [7:0] chanWait;
   logic [7:0] chanDisabled_r;
   logic [7:0] chanDisabled_nxt;
   logic       caseOne;
   logic       supplyBad;
   logic       supplyWait_r;
   logic       supplyWait_nxt;
   logic       waitAck;

   // any fault disables a channel until the fault clears and is acknowledged
   assign chanFault = unavailFault | shortPFault | overloadFault | testFault;
   assign chanWait  = chanDisabled_r & ~chanFault;
   assign waitAck   = |chanWait;
   assign chanDisabled_nxt = chanFault |
                             (chanDisabled_r & ~{8{userAck}});
   assign caseOne   = ~appCaseTwo;
   assign supplyBad = supplyHigh | supplyLow;
   assign supplyWait_nxt = supplyBad | (supplyWait_r & ~userAck);

   // disable and supply wait latches
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         chanDisabled_r <= '0;
         supplyWait_r   <= 1'b0;
      end else begin
         chanDisabled_r <= chanDisabled_nxt;
         supplyWait_r   <= supplyWait_nxt;
      end
   end

   // ****************************************************
   // condition vector
   // ****************************************************
   logic [NSRC-1:0] cond;

   // module scoped conditions
   assign cond[`SDE_I_DESTMIS] = destMismatch;
   assign cond[`SDE_I_DESTBAD] = destIllegal;
   assign cond[`SDE_I_SRCBAD]  = srcIllegal;
   assign cond[`SDE_I_WDZERO]  = wdTimeZero;
   assign cond[`SDE_I_SILHIGH] = silExceeded;
   assign cond[`SDE_I_CRCLEN]  = crcLenMismatch;
   assign cond[`SDE_I_PARVER]  = parVersionBad;
   assign cond[`SDE_I_SAVETO]  = iparSaveTimeout;
   assign cond[`SDE_I_RESTTO]  = iparRestoreTimeout;
   assign cond[`SDE_I_IPARCRC] = iparInconsistent;
   assign cond[`SDE_I_MSGCRC]  = msgCrcFault & caseOne;
   assign cond[`SDE_I_COMMTO]  = commTimeout & caseOne;
   assign cond[`SDE_I_INTSUP]  = intSupplyFault & caseOne;
   assign cond[`SDE_I_ADDRMEM] = addrMemFault;
   assign cond[`SDE_I_SUPHIGH] = supplyHigh;
   assign cond[`SDE_I_SUPLOW]  = supplyLow;
   assign cond[`SDE_I_ACKREQ]  = waitAck;

   // channel scoped conditions, eight per group
   for (genvar ch = 0; ch < `SDE_NCH; ch++) begin : g_chan
      assign cond[`SDE_B_UNAVAIL + ch]  = unavailFault[ch];
      assign cond[`SDE_B_SHORTP + ch]   = shortPFault[ch] &
                                          shortPEnable[ch] & caseOne;
      assign cond[`SDE_B_OVERLD + ch]   = overloadFault[ch] & caseOne;
      assign cond[`SDE_B_TESTFAIL + ch] = testFault[ch];
   end

   // ****************************************************
   // event latch and issue
   // ****************************************************
   logic [NSRC-1:0] pend;
   logic [NSRC-1:0] clr;
   logic            anyPend;
   logic            load;
   logic [5:0]      pick;
   logic [5:0]      chanOff;

   sde_event_latch #(
      .N (NSRC)
   ) u_latch (
      .clock (clock),
      .rst   (rst),
      .cond  (cond),
      .clr   (clr),
      .pend  (pend)
   );

   // one pending event moves to the output when it is free
   assign anyPend = |pend;
   assign load    = anyPend & (~intValid_r | intTaken);
   assign pick    = firstSet(pend);
   assign clr     = load ? (NSRC'(1) << pick) : '0;
   assign chanOff = pick - 6'(`SDE_B_UNAVAIL);

   logic                intValid_r;
   sde_pkg::sde_code_t  intCode_r;
   sde_pkg::sde_scope_e intScope_r;
   logic [2:0]          intChannel_r;

   // interrupt output register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         intValid_r   <= 1'b0;
         intCode_r    <= '0;
         intScope_r   <= sde_pkg::SDE_MODULE;
         intChannel_r <= '0;
      end else if (load) begin
         intValid_r   <= 1'b1;
         intCode_r    <= srcCode(pick);
         intScope_r   <= (pick < 6'(NMOD)) ? sde_pkg::SDE_MODULE
                                           : sde_pkg::SDE_CHANNEL;
         intChannel_r <= (pick < 6'(NMOD)) ? 3'h0 : chanOff[2:0];
      end else if (intTaken) begin
         intValid_r   <= 1'b0;
      end
   end

   // ****************************************************
   // indicators
   // ****************************************************
   logic       flashTick;
   logic       flashPhase;
   logic [7:0] ledStatus_r;
   logic [7:0] ledDiag_r;
   logic       runLed_r;
   logic       errorLed_r;
   logic [7:0] ledStatus_nxt;
   logic [7:0] ledDiag_nxt;
   logic       errorActive;

   sde_flash_div #(
      .HALF_CYCLES (FLASH_HALF_CYCLES)
   ) u_flash (
      .clock (clock),
      .rst   (rst),
      .tick  (flashTick),
      .phase (flashPhase)
   );

   // supply fault overrides channel display
   assign ledStatus_nxt = supplyWait_r ? 8'h00 :
                          ((chanWait & {8{flashPhase}}) |
                           ~chanDisabled_r);
   assign ledDiag_nxt   = supplyWait_r ? 8'hff : chanFault;
   assign errorActive   = supplyWait_r | anyPend | intValid_r |
                          (|chanDisabled_r);

   // indicator registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         ledStatus_r <= '0;
         ledDiag_r   <= '0;
         runLed_r    <= 1'b0;
         errorLed_r  <= 1'b0;
      end else begin
         ledStatus_r <= ledStatus_nxt;
         ledDiag_r   <= ledDiag_nxt;
         runLed_r    <= 1'b1;
         errorLed_r  <= errorActive & flashPhase;
      end
   end

   // output drive
   assign intValid               = intValid_r;
   assign intCode                = intCode_r;
   assign intScope               = intScope_r;
   assign intChannel             = intChannel_r;
   assign chanEnabled            = ~chanDisabled_r;
   assign supplyWait             = supplyWait_r;
   assign channelIndicatorStatus = ledStatus_r;
   assign channelIndicatorDiag   = ledDiag_r;
   assign runLed                 = runLed_r;
   assign errorLed               = errorLed_r;

   // ****************************************************
   // checks
   // ****************************************************
   a_event_issued: assert property (
      @(posedge clock) disable iff (rst)
      anyPend && !intValid_r |=> intValid_r)
      else $error("pending event not issued");

   a_valid_holds: assert property (
      @(posedge clock) disable iff (rst)
      intValid_r && !intTaken |=> intValid_r && $stable(intCode_r))
      else $error("interrupt dropped before taken");

   a_scope_module: assert property (
      @(posedge clock) disable iff (rst)
      intValid_r && intCode_r == `SDE_C_DESTMIS
      |-> intScope_r == sde_pkg::SDE_MODULE)
      else $error("code 40 without module scope");

   a_scope_chan: assert property (
      @(posedge clock) disable iff (rst)
      intValid_r && (intCode_r == `SDE_C_UNAVAIL ||
                     intCode_r == `SDE_C_OVERLD)
      |-> intScope_r == sde_pkg::SDE_CHANNEL)
      else $error("channel code without channel scope");

   a_code_range: assert property (
      @(posedge clock) disable iff (rst)
      intValid_r |-> intCode_r <= `SDE_C_TESTFAIL && intCode_r != '0)
      else $error("fault code out of range");

   a_supply_leds: assert property (
      @(posedge clock) disable iff (rst)
      supplyWait_r |=> channelIndicatorStatus == 8'h00 &&
                       channelIndicatorDiag == 8'hff && runLed)
      else $error("supply fault indicator pattern wrong");

   a_chan_held: assert property (
      @(posedge clock) disable iff (rst)
      chanDisabled_r[0] && !userAck |=> !chanEnabled[0])
      else $error("channel re-enabled without acknowledge");

   a_ack_report: assert property (
      @(posedge clock) disable iff (rst)
      waitAck && !$past(waitAck) |=> pend[`SDE_I_ACKREQ])
      else $error("acknowledge request not latched");

   a_short_mask: assert property (
      @(posedge clock) disable iff (rst)
      !shortPEnable[0] |-> !cond[`SDE_B_SHORTP])
      else $error("disabled short to P still reported");

   a_overload_on: assert property (
      @(posedge clock) disable iff (rst)
      overloadFault[3] && caseOne |-> cond[`SDE_B_OVERLD + 3])
      else $error("overload condition masked");

   a_case_two_crc: assert property (
      @(posedge clock) disable iff (rst)
      appCaseTwo |-> !cond[`SDE_I_MSGCRC] && !cond[`SDE_I_COMMTO])
      else $error("case-one fault raised in case two");
endmodule

// *** hw/sde_consts.svh ***
`ifndef SDE_CONSTS_SVH
`define SDE_CONSTS_SVH

// ****************************************************
// widths and counts
// ****************************************************
`define SDE_CODE_W 12
`define SDE_NCH 8
`define SDE_NMOD 17
`define SDE_NSRC 49
`define SDE_IDX_W 6

// ****************************************************
// fault codes
// ****************************************************
`define SDE_C_UNAVAIL 12'h01f
`define SDE_C_DESTMIS 12'h040
`define SDE_C_DESTBAD 12'h041
`define SDE_C_SRCBAD 12'h042
`define SDE_C_WDZERO 12'h043
`define SDE_C_SILHIGH 12'h044
`define SDE_C_CRCLEN 12'h045
`define SDE_C_PARVER 12'h046
`define SDE_C_SAVETO 12'h049
`define SDE_C_RESTTO 12'h04a
`define SDE_C_IPARCRC 12'h04b
`define SDE_C_MSGCRC 12'h04d
`define SDE_C_COMMTO 12'h04e
`define SDE_C_ACKREQ 12'h04f
`define SDE_C_INTSUP 12'h104
`define SDE_C_SHORTP 12'h306
`define SDE_C_OVERLD 12'h307
`define SDE_C_ADDRMEM 12'h30d
`define SDE_C_SUPHIGH 12'h321
`define SDE_C_SUPLOW 12'h322
`define SDE_C_TESTFAIL 12'h332

// ****************************************************
// source indices: module sources, then channel groups
// ****************************************************
`define SDE_I_DESTMIS 0
`define SDE_I_DESTBAD 1
`define SDE_I_SRCBAD 2
`define SDE_I_WDZERO 3
`define SDE_I_SILHIGH 4
`define SDE_I_CRCLEN 5
`define SDE_I_PARVER 6
`define SDE_I_SAVETO 7
`define SDE_I_RESTTO 8
`define SDE_I_IPARCRC 9
`define SDE_I_MSGCRC 10
`define SDE_I_COMMTO 11
`define SDE_I_INTSUP 12
`define SDE_I_ADDRMEM 13
`define SDE_I_SUPHIGH 14
`define SDE_I_SUPLOW 15
`define SDE_I_ACKREQ 16
`define SDE_B_UNAVAIL 17
`define SDE_B_SHORTP 25
`define SDE_B_OVERLD 33
`define SDE_B_TESTFAIL 41

// ****************************************************
// timing
// ****************************************************
`define SDE_CLK_HZ 25000000
`define SDE_FLASH_HALF_MS 250
`define SDE_FLASH_HALF_CYC (`SDE_CLK_HZ / 1000 * `SDE_FLASH_HALF_MS)

`endif

// *** hw/sde_pkg.sv ***
// ****************************************************
// shared types
// ****************************************************
package sde_pkg;
   typedef enum logic {
      SDE_CHANNEL = 1'b0,
      SDE_MODULE  = 1'b1
   } sde_scope_e;
   typedef logic [11:0] sde_code_t;
endpackage

// *** hw/sde_event_latch.sv ***
`timescale 1ns/1ps
// ****************************************************
// sticky pending bits, one per condition rising edge
// ****************************************************
module sde_event_latch #(
   parameter int N = 49
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic [N-1:0] cond,
   input  wire logic [N-1:0] clr,
   output logic      [N-1:0] pend
);
   logic [N-1:0] prev_r;
   logic [N-1:0] pend_r;
   logic [N-1:0] rise;
   logic [N-1:0] pend_nxt;

   initial begin
      if (N < 1) $error("sde_event_latch: N must be at least 1");
   end

   // a new event wins over a clear in the same cycle
   assign rise     = cond & ~prev_r;
   assign pend_nxt = (pend_r & ~clr) | rise;
   assign pend     = pend_r;

   // edge history and pending store
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         prev_r <= '0;
         pend_r <= '0;
      end else begin
         prev_r <= cond;
         pend_r <= pend_nxt;
      end
   end
endmodule

// *** hw/sde_flash_div.sv ***
`timescale 1ns/1ps
// ****************************************************
// indicator flash divider
// ****************************************************
module sde_flash_div #(
   parameter int HALF_CYCLES = 6250000
) (
   input  wire logic clock,
   input  wire logic rst,
   output logic      tick,
   output logic      phase
);
   localparam int CW = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(HALF_CYCLES - 1);

   logic [CW-1:0] cnt_r;
   logic          phase_r;
   logic          wrap;

   initial begin
      if (HALF_CYCLES < 1) $error("sde_flash_div: HALF_CYCLES < 1");
   end

   // one-cycle enable at each half period
   assign wrap  = (cnt_r == LAST);
   assign tick  = wrap;
   assign phase = phase_r;

   // counter and flash phase
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cnt_r   <= '0;
         phase_r <= 1'b0;
      end else begin
         cnt_r   <= wrap ? '0 : cnt_r + 1'b1;
         phase_r <= phase_r ^ wrap;
      end
   end
endmodule

// *** tb/sde_ctrl_model.sv ***
`timescale 1ns/1ps
// ****************************************************
// supervising controller: takes interrupts, prompt or slow
// ****************************************************
module sde_ctrl_model (
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic intValid,
   input  wire logic fast,
   output logic      intTaken
);
   int cnt = 0;
   initial intTaken = 1'b0;
   // take each presented interrupt once, fast after 0 stall cycles, slow after 2, or 3 when it follows a take directly
   always @(posedge clock) begin
      #1;
      if (rst || intTaken || !intValid) cnt = 0;
      else cnt = cnt + 1;
      intTaken = intValid && (fast || cnt >= 3);
   end
endmodule

// *** tb/tb_safety_input_diag_event_encoder.sv ***
`timescale 1ns/1ps
// ****************************************************
// bench top: stimulus, expected-event model, verdict
// ****************************************************
module tb_safety_input_diag_event_encoder;
   logic                clock        = 1'b0;
   logic                rst          = 1'b1;
   logic [7:0]          chF [4]      = '{default: 8'h00};
   logic [7:0]          shortPEnable = 8'hff;
   logic [15:0]         modF         = 16'h0000;
   logic                appCaseTwo   = 1'b0;
   logic                userAck      = 1'b0;
   logic                fast         = 1'b0;
   logic                intTaken;
   logic                intValid;
   sde_pkg::sde_code_t  intCode;
   sde_pkg::sde_scope_e intScope;
   logic [2:0]          intChannel;
   logic [7:0]          chanEnabled;
   logic [7:0]          chanSt;
   logic [7:0]          chanDg;
   logic                supplyWait;
   logic                runLed;
   logic                errorLed;
   int                  n_fail       = 0;
   int                  comparisons  = 0;
   int                  nt;
   logic                e;
   logic [2:0]          ch;
   logic [31:0]         seed         = 32'hbf450c84;
   sde_pkg::sde_code_t  qc [$];
   sde_pkg::sde_scope_e qs [$];
   logic [2:0]          qh [$];
   sde_pkg::sde_code_t  modCode [16] = '{12'h040, 12'h041, 12'h042,
      12'h043, 12'h044, 12'h045, 12'h046, 12'h049, 12'h04a, 12'h04b,
      12'h04d, 12'h04e, 12'h104, 12'h30d, 12'h321, 12'h322};
   sde_pkg::sde_code_t  chCode [4]   = '{12'h01f, 12'h306, 12'h307, 12'h332};

   sde_encoder_top #(.FLASH_HALF_CYCLES(4)) sde_encoder_top_i (
      .clock(clock), .rst(rst), .unavailFault(chF[0]), .shortPFault(chF[1]),
      .overloadFault(chF[2]), .testFault(chF[3]),
      .shortPEnable(shortPEnable), .appCaseTwo(appCaseTwo),
      .destMismatch(modF[0]), .destIllegal(modF[1]), .srcIllegal(modF[2]),
      .wdTimeZero(modF[3]), .silExceeded(modF[4]), .crcLenMismatch(modF[5]),
      .parVersionBad(modF[6]), .iparSaveTimeout(modF[7]),
      .iparRestoreTimeout(modF[8]), .iparInconsistent(modF[9]),
      .msgCrcFault(modF[10]), .commTimeout(modF[11]),
      .intSupplyFault(modF[12]), .addrMemFault(modF[13]),
      .supplyHigh(modF[14]), .supplyLow(modF[15]), .userAck(userAck),
      .intTaken(intTaken), .intValid(intValid), .intCode(intCode),
      .intScope(intScope), .intChannel(intChannel),
      .chanEnabled(chanEnabled), .supplyWait(supplyWait),
      .channelIndicatorStatus(chanSt), .channelIndicatorDiag(chanDg),
      .runLed(runLed), .errorLed(errorLed));

   sde_ctrl_model sde_ctrl_model_i (
      .clock(clock), .rst(rst), .intValid(intValid), .fast(fast),
      .intTaken(intTaken));

   // clock, 40 ns period
   always #20 clock = ~clock;

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("Error %0t: %s", $time, msg);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic expect_ev(input sde_pkg::sde_code_t c,
                            input sde_pkg::sde_scope_e s, input logic [2:0] h);
      qc.push_back(c);
      qs.push_back(s);
      qh.push_back(h);
   endtask

   task automatic drain();
      for (int i = 0; i < 200 && qc.size() != 0; i++) tick(1);
      check(qc.size() == 0, "expected interrupt missing");
      tick(1);
   endtask

   task automatic ack();
      userAck = 1'b1;
      tick(1);
      userAck = 1'b0;
      tick(2);
   endtask

   task automatic end_sim();
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   // every accepted interrupt against the expected list, in order
   always @(posedge clock) begin
      if (intValid === 1'b1 && intTaken === 1'b1) begin
         if (qc.size() == 0) check(1'b0, "unexpected interrupt");
         else begin
            check(intCode === qc[0] && intScope === qs[0] &&
                  intChannel === qh[0], "interrupt content");
            void'(qc.pop_front());
            void'(qs.pop_front());
            void'(qh.pop_front());
         end
      end
   end

   // main sequence
   initial begin
      tick(20);
      rst = 1'b0;
      tick(2);
      // module faults one at a time, supply faults with lamp pattern
      for (int i = 0; i < 16; i++) begin
         seed = lfsr(seed);
         fast = seed[0];
         modF[i] = 1'b1;
         expect_ev(modCode[i], sde_pkg::SDE_MODULE, 3'h0);
         drain();
         if (i >= 14) begin
            check(chanSt === 8'h00 && chanDg === 8'hff && runLed === 1'b1 &&
                  supplyWait === 1'b1, "supply fault lamps");
            nt = 0;
            e = errorLed;
            for (int j = 0; j < 12; j++) begin
               tick(1);
               if (errorLed !== e) nt++;
               e = errorLed;
            end
            check(nt >= 2, "error lamp not flashing");
         end
         modF[i] = 1'b0;
         tick(2);
         if (i >= 14) check(supplyWait === 1'b1, "wait dropped early");
         ack();
         check(supplyWait === 1'b0, "supply wait stuck");
      end
      // two at once, taken back to back, lowest code first
      fast = 1'b1;
      modF[1:0] = 2'b11;
      expect_ev(12'h040, sde_pkg::SDE_MODULE, 3'h0);
      expect_ev(12'h041, sde_pkg::SDE_MODULE, 3'h0);
      drain();
      modF = 16'h0000;
      // channel faults: report, disable, clear, acknowledge
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         ch = seed[3:1];
         fast = seed[0];
         chF[k][ch] = 1'b1;
         expect_ev(chCode[k], sde_pkg::SDE_CHANNEL, ch);
         drain();
         check(chanEnabled[ch] === 1'b0, "channel not disabled");
         chF[k][ch] = 1'b0;
         expect_ev(12'h04f, sde_pkg::SDE_MODULE, 3'h0);
         drain();
         check(chanEnabled[ch] === 1'b0, "enabled before ack");
         ack();
         check(chanEnabled[ch] === 1'b1, "channel not re-enabled");
      end
      // masked short-to-P report: only the reintegration code
      shortPEnable[ch] = 1'b0;
      chF[1][ch] = 1'b1;
      tick(6);
      chF[1][ch] = 1'b0;
      expect_ev(12'h04f, sde_pkg::SDE_MODULE, 3'h0);
      drain();
      ack();
      shortPEnable = 8'hff;
      // application case 2 suppresses case-1-only codes
      appCaseTwo = 1'b1;
      modF[12:10] = 3'b111;
      tick(6);
      modF = 16'h0000;
      tick(2);
      appCaseTwo = 1'b0;
      tick(3);
      check(qc.size() == 0 && intValid === 1'b0, "case 2 reported");
      end_sim();
   end

   // watchdog
   initial begin
      #800000;
      n_fail++;
      $display("Error %0t: timeout", $time);
      end_sim();
   end
endmodule
